// file: verilog/breaker_supervision_pkg.sv
// Purpose: Shared constants and types for the breaker command supervision.
// Assumes: 125 MHz system clock; times are given in milliseconds.
// Notes:   Cycle counts are derived here and used as top-level defaults.
package breaker_supervision_pkg;

	// Decoded breaker position codes
	localparam logic [1:0] POS_INDETERMINATE_CODE = 2'h0;
	localparam logic [1:0] POS_OPEN_CODE          = 2'h1;
	localparam logic [1:0] POS_CLOSED_CODE        = 2'h2;
	localparam logic [1:0] POS_DISTURBED_CODE     = 2'h3;

	// Clock rate and supervision times
	localparam int unsigned CLK_KHZ          = 125000;
	localparam int unsigned CONTRA_TIME_MS   = 100;
	localparam int unsigned SUPV_TIME_MS     = 1000;
	localparam int unsigned SYNC_TIME_MS     = 200;
	localparam logic [31:0] CONTRA_CYCLES_DEF = 32'(CONTRA_TIME_MS * CLK_KHZ);
	localparam logic [31:0] SUPV_CYCLES_DEF   = 32'(SUPV_TIME_MS * CLK_KHZ);
	localparam logic [31:0] SYNC_CYCLES_DEF   = 32'(SYNC_TIME_MS * CLK_KHZ);

	// Number of interlock inputs per direction
	localparam int unsigned NUM_LOCKOUTS = 3;

	// Command execution supervision outcome flags
	typedef struct packed {
		logic cmd_done_ok;
		logic cmd_fail_contradictory;
		logic cmd_fail_trip_pending;
		logic cmd_redundant_direction;
		logic cmd_close_during_open;
		logic cmd_fail_breaker_unready;
		logic cmd_fail_field_lockout;
		logic cmd_fail_sync_window;
		logic cmd_fail_breaker_withdrawn;
	} cmd_status_s;

	// Command supervision states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SYNC,
		ST_EXEC
	} cmd_state_e;

endpackage : breaker_supervision_pkg

// file: verilog/breaker_command_supervision.sv
// Purpose: Position decode, interlock summary and command supervision
//          for one controlled circuit breaker.
// Assumes: All inputs synchronous to CLK; CLOSE_REQ/OPEN_REQ are pulses.
// Notes:   One command is supervised at a time; later requests are ignored, except a close during an open, which is flagged.

// Overview of operation
// RULE_01: Position code is 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// RULE_02: Contradicting contacts show disturbed only after the contradiction timer.
// RULE_03: One-contact mode uses the closed contact only and flags the mode.
// RULE_04: Closed, open, not-closed and indeterminate flags follow the code.
// RULE_05: Close interlock status is the OR of the close interlock inputs.
// RULE_06: Open interlock status is the OR of the open interlock inputs.
// RULE_07: Success flag when the breaker reaches the requested end position.
// RULE_08: Failure flag when a command ends with the breaker disturbed.
// RULE_09: Commands are refused and flagged while a trip is pending.
// RULE_10: Flag a command requesting the position already held.
// RULE_11: Flag a close request arriving while an open command is pending.
// RULE_12: Flag and refuse a command while the breaker is not ready.
// RULE_13: Refuse and flag a command blocked by active field interlocking.
// RULE_14: Synchronised close is abandoned and flagged if sync never arrives.
// RULE_15: A command fails with its own flag when the breaker is removed; removal is ignored while waiting in ST_SYNC.
// RULE_16: Removed status follows the removed input.
// RULE_17: Ready status mirrors the ready input.
// RULE_18: Optionally merge the protection close request and indicate it.
// RULE_19: Trip request, its acknowledgement and dwell are separate outputs.
// RULE_20: Breaker drives a closed-reporting and an open-reporting contact.
// RULE_21: Sync source asserts in-sync within the synchronisation window.
// RULE_22: Flags clear on the next command taken; timers are parameters.
// RULE_23: Trip request holds until acknowledged after the trip condition ends.
module breaker_command_supervision
	import breaker_supervision_pkg::*;
#(
	parameter logic [31:0] CONTRA_CYCLES = CONTRA_CYCLES_DEF,
	parameter logic [31:0] SUPV_CYCLES   = SUPV_CYCLES_DEF,
	parameter logic [31:0] SYNC_CYCLES   = SYNC_CYCLES_DEF
) (
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    AUX_CLOSED,
	input  wire logic                    AUX_OPEN,
	input  wire logic                    ONE_CONTACT_MODE,
	input  wire logic                    BREAKER_READY,
	input  wire logic                    BREAKER_REMOVED,
	input  wire logic [NUM_LOCKOUTS-1:0] CLOSE_LOCKOUT_INPUT,
	input  wire logic [NUM_LOCKOUTS-1:0] OPEN_LOCKOUT_INPUT,
	input  wire logic                    CLOSE_REQ,
	input  wire logic                    OPEN_REQ,
	input  wire logic                    SYNC_CLOSE_MODE,
	input  wire logic                    IN_SYNC,
	input  wire logic                    PROT_CLOSE_REQ,
	input  wire logic                    INCL_PROT_CLOSE,
	input  wire logic                    PROT_TRIP,
	input  wire logic                    TRIP_ACK,
	input  wire logic                    AUTO_ACK,
	output logic        [1:0]            POSITION,
	output logic                         ONE_CONTACT_MODE_FLAG,
	output logic                         POS_CLOSED,
	output logic                         POS_OPEN,
	output logic                         POS_NOT_CLOSED,
	output logic                         POS_INDETERMINATE,
	output logic                         POS_DISTURBED,
	output logic                         CLOSE_LOCKOUT,
	output logic                         OPEN_LOCKOUT,
	output logic                         READY,
	output logic                         REMOVED,
	output logic                         CLOSE_CMD,
	output logic                         OPEN_CMD,
	output logic                         PROT_CLOSE_INCLUDED,
	output logic                         PROTECTION_TRIP_REQUEST,
	output logic                         TRIP_ACKNOWLEDGE,
	output logic                         DWELL_ACTIVE,
	output cmd_status_s                  CMD_STATUS
);

	logic [31:0] contra_cnt;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic [1:0]  next_pos;
	cmd_state_e  state;
	cmd_state_e  next_state;
	logic        dir;
	logic        next_dir;
	cmd_status_s next_status;
	logic        trip_request;

	// Position decode; a contradiction needs both contacts to agree
	wire contra      = ~ONE_CONTACT_MODE & (AUX_CLOSED == AUX_OPEN);
	wire contra_done = (contra_cnt >= CONTRA_CYCLES - 32'd1);
	wire [1:0] clean_pos = AUX_CLOSED ? POS_CLOSED_CODE : POS_OPEN_CODE;

	always_comb begin
		if (!contra) begin
			next_pos = clean_pos; // see RULE_03
		end else if (contra_done) begin
			next_pos = POS_DISTURBED_CODE; // see RULE_02
		end else begin
			next_pos = POS_INDETERMINATE_CODE; // see RULE_01
		end
	end

	// Contradiction timer saturates so disturbed stays until it clears
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			contra_cnt <= '0;
		end else if (!contra) begin
			contra_cnt <= '0;
		end else if (!contra_done) begin
			contra_cnt <= contra_cnt + 32'd1; // see RULE_02
		end
	end

	// Status flags decoded from the registered code
	assign POS_CLOSED        = (POSITION == POS_CLOSED_CODE); // see RULE_04
	assign POS_OPEN          = (POSITION == POS_OPEN_CODE);
	assign POS_NOT_CLOSED    = ~POS_CLOSED;
	assign POS_INDETERMINATE = (POSITION == POS_INDETERMINATE_CODE);
	assign POS_DISTURBED     = (POSITION == POS_DISTURBED_CODE);

	// Request evaluation; a simultaneous close loses to the open
	wire req_any     = CLOSE_REQ | OPEN_REQ;
	wire req_close   = CLOSE_REQ & ~OPEN_REQ;
	wire already     = req_close ? POS_CLOSED : POS_OPEN;
	wire lock_hit    = req_close ? CLOSE_LOCKOUT : OPEN_LOCKOUT;
	wire reached     = dir ? POS_CLOSED : POS_OPEN;
	wire sync_expire = (cnt >= SYNC_CYCLES - 32'd1);
	wire supv_expire = (cnt >= SUPV_CYCLES - 32'd1);

	// Command supervision state machine
	always_comb begin
		next_state  = state;
		next_status = CMD_STATUS;
		next_dir    = dir;
		next_cnt    = cnt + 32'd1;
		case (state)
			ST_IDLE: begin
				next_cnt = '0;
				if (req_any) begin
					next_status = '0; // see RULE_22
					next_dir    = req_close;
					next_status.cmd_close_during_open = CLOSE_REQ & OPEN_REQ;
					if (trip_request) begin
						next_status.cmd_fail_trip_pending = 1'b1; // see RULE_09
					end else if (BREAKER_REMOVED) begin
						next_status.cmd_fail_breaker_withdrawn = 1'b1; // see RULE_15
					end else if (!BREAKER_READY) begin
						next_status.cmd_fail_breaker_unready = 1'b1; // see RULE_12
					end else if (already) begin
						next_status.cmd_redundant_direction = 1'b1; // see RULE_10
					end else if (lock_hit) begin
						next_status.cmd_fail_field_lockout = 1'b1; // see RULE_13
					end else if (req_close && SYNC_CLOSE_MODE) begin
						next_state = ST_SYNC;
					end else begin
						next_state = ST_EXEC;
					end
				end
			end
			ST_SYNC: begin
				if (IN_SYNC) begin
					next_state = ST_EXEC; // see RULE_21
					next_cnt   = '0;
				end else if (sync_expire) begin
					next_status.cmd_fail_sync_window = 1'b1; // see RULE_14
					next_state = ST_IDLE;
				end
			end
			ST_EXEC: begin
				if (!dir && CLOSE_REQ) begin
					next_status.cmd_close_during_open = 1'b1; // see RULE_11
				end
				if (BREAKER_REMOVED) begin
					next_status.cmd_fail_breaker_withdrawn = 1'b1; // see RULE_15
					next_state = ST_IDLE;
				end else if (reached) begin
					next_status.cmd_done_ok = 1'b1; // see RULE_07
					next_state = ST_IDLE;
				end else if (POS_DISTURBED || supv_expire) begin
					next_status.cmd_fail_contradictory = 1'b1; // see RULE_08
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Trip request holds until acknowledged once the trip has gone
	wire trip_clear = trip_request & ~PROT_TRIP & (TRIP_ACK | AUTO_ACK);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			trip_request     <= 1'b0;
			TRIP_ACKNOWLEDGE <= 1'b0;
		end else begin
			trip_request     <= PROT_TRIP | (trip_request & ~trip_clear);
			TRIP_ACKNOWLEDGE <= trip_clear; // see RULE_23
		end
	end

	assign PROTECTION_TRIP_REQUEST = trip_request; // see RULE_19

	// Supervision registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state      <= ST_IDLE;
			dir        <= 1'b0;
			cnt        <= '0;
			CMD_STATUS <= '0;
		end else begin
			state      <= next_state;
			dir        <= next_dir;
			cnt        <= next_cnt;
			CMD_STATUS <= next_status;
		end
	end

	// Registered mirrors and drive outputs; drive stays up through dwell
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			POSITION              <= POS_INDETERMINATE_CODE;
			ONE_CONTACT_MODE_FLAG <= 1'b0;
			CLOSE_LOCKOUT         <= 1'b0;
			OPEN_LOCKOUT          <= 1'b0;
			READY                 <= 1'b0;
			REMOVED               <= 1'b0;
			CLOSE_CMD             <= 1'b0;
			OPEN_CMD              <= 1'b0;
			PROT_CLOSE_INCLUDED   <= 1'b0;
			DWELL_ACTIVE          <= 1'b0;
		end else begin
			POSITION              <= next_pos; // see RULE_01
			ONE_CONTACT_MODE_FLAG <= ONE_CONTACT_MODE; // see RULE_03
			CLOSE_LOCKOUT         <= |CLOSE_LOCKOUT_INPUT; // see RULE_05
			OPEN_LOCKOUT          <= |OPEN_LOCKOUT_INPUT; // see RULE_06
			READY                 <= BREAKER_READY; // see RULE_17
			REMOVED               <= BREAKER_REMOVED; // see RULE_16
			CLOSE_CMD             <= ((next_state == ST_EXEC) & next_dir)
				| (INCL_PROT_CLOSE & PROT_CLOSE_REQ); // see RULE_18
			OPEN_CMD              <= (next_state == ST_EXEC) & ~next_dir;
			PROT_CLOSE_INCLUDED   <= INCL_PROT_CLOSE; // see RULE_18
			DWELL_ACTIVE          <= (next_state == ST_EXEC); // see RULE_19
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	property p_one_contact;
		ONE_CONTACT_MODE |=> POSITION ==
			($past(AUX_CLOSED) ? POS_CLOSED_CODE : POS_OPEN_CODE);
	endproperty
	a_one_contact: assert property (p_one_contact) // see RULE_03
		else $error("one-contact position wrong");

	property p_disturbed;
		POS_DISTURBED |-> $past(contra) && $past(contra_done);
	endproperty
	a_disturbed: assert property (p_disturbed) // see RULE_02
		else $error("disturbed without expired contradiction");

	property p_close_lock;
		(|CLOSE_LOCKOUT_INPUT) |=> CLOSE_LOCKOUT;
	endproperty
	a_close_lock: assert property (p_close_lock) // see RULE_05
		else $error("close interlock status missing");

	property p_trip_refuse;
		(state == ST_IDLE && req_any && trip_request) |=>
			CMD_STATUS.cmd_fail_trip_pending && state == ST_IDLE;
	endproperty
	a_trip_refuse: assert property (p_trip_refuse) // see RULE_09
		else $error("command taken during pending trip");

	property p_unready;
		(state == ST_IDLE && req_any && !trip_request && !BREAKER_REMOVED
			&& !BREAKER_READY) |=> CMD_STATUS.cmd_fail_breaker_unready
			##1 !DWELL_ACTIVE;
	endproperty
	a_unready: assert property (p_unready) // see RULE_12
		else $error("unready breaker not flagged");

	property p_sync_timeout;
		(state == ST_SYNC && !IN_SYNC && cnt == SYNC_CYCLES - 32'd1) |=>
			CMD_STATUS.cmd_fail_sync_window && state == ST_IDLE;
	endproperty
	a_sync_timeout: assert property (p_sync_timeout) // see RULE_14
		else $error("sync timeout not flagged");

	property p_done_ok;
		(state == ST_EXEC && !BREAKER_REMOVED && reached) |=>
			CMD_STATUS.cmd_done_ok && !CLOSE_CMD[*1] ##0 !OPEN_CMD;
	endproperty
	a_done_ok: assert property (p_done_ok) // see RULE_07
		else $error("success not reported");

	property p_trip_hold;
		(trip_request && !trip_clear) |=> PROTECTION_TRIP_REQUEST;
	endproperty
	a_trip_hold: assert property (p_trip_hold) // see RULE_23
		else $error("trip request dropped before acknowledge");

	property p_removed;
		$rose(BREAKER_REMOVED) |=> REMOVED ##1 $stable(REMOVED) || !$past(BREAKER_REMOVED);
	endproperty
	a_removed: assert property (p_removed) // see RULE_16
		else $error("removed status not following input");

endmodule : breaker_command_supervision

// file: verification/breaker_drive_model.sv
// Purpose: Behavioural breaker drive with two auxiliary position contacts.
// Assumes: Commands are levels from the supervision block.
// Notes:   Both contacts read low while travelling or when jammed.
module breaker_drive_model #(
	parameter int TRAVEL = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic close_cmd,
	input  wire logic open_cmd,
	input  wire logic jam,
	output logic      aux_closed,
	output logic      aux_open
);
	timeunit 1ns;
	timeprecision 1ps;
	logic closed;
	int   cnt;
	logic moving;

	// Contacts flip only after the full travel time, as a real drive would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			closed <= 1'b0;
			cnt    <= 0;
		end else if ((close_cmd && !closed) || (open_cmd && closed)) begin
			if (cnt == TRAVEL - 1) begin
				closed <= ~closed;
				cnt    <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			cnt <= 0;
		end
	end

	// Mid-travel both contacts open, so the relay sees a short contradiction
	assign moving     = (cnt != 0);
	assign aux_closed = !jam && !moving && closed;
	assign aux_open   = !jam && !moving && !closed;
endmodule : breaker_drive_model

// file: verification/breaker_command_supervision_bench.sv
// Purpose: Self-checking bench for the breaker command supervision.
// Assumes: Short timer parameters 8, 40 and 20 cycles.
// Notes:   Breaker model starts open; scenarios run in a fixed order.
module breaker_command_supervision_bench;
	import breaker_supervision_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RST = 1, AUX_CLOSED, AUX_OPEN, jam = 0;
	logic ONE_CONTACT_MODE = 0, BREAKER_READY = 1, BREAKER_REMOVED = 0;
	logic [NUM_LOCKOUTS-1:0] CLOSE_LOCKOUT_INPUT = '0, OPEN_LOCKOUT_INPUT = '0;
	logic CLOSE_REQ = 0, OPEN_REQ = 0, SYNC_CLOSE_MODE = 0, IN_SYNC = 0;
	logic PROT_CLOSE_REQ = 0, INCL_PROT_CLOSE = 0, PROT_TRIP = 0;
	logic TRIP_ACK = 0, AUTO_ACK = 0;
	logic [1:0] POSITION;
	logic ONE_CONTACT_MODE_FLAG, POS_CLOSED, POS_OPEN, POS_NOT_CLOSED;
	logic POS_INDETERMINATE, POS_DISTURBED, CLOSE_LOCKOUT, OPEN_LOCKOUT;
	logic READY, REMOVED, CLOSE_CMD, OPEN_CMD, PROT_CLOSE_INCLUDED;
	logic PROTECTION_TRIP_REQUEST, TRIP_ACKNOWLEDGE, DWELL_ACTIVE;
	cmd_status_s CMD_STATUS;
	int errors = 0, n_tests = 0, cycles = 0;

	always #4 CLK = ~CLK;

	breaker_command_supervision #(.CONTRA_CYCLES(32'h8), .SUPV_CYCLES(32'h28),
		.SYNC_CYCLES(32'h14)) uut (.CLK(CLK), .RST(RST),
		.AUX_CLOSED(AUX_CLOSED), .AUX_OPEN(AUX_OPEN),
		.ONE_CONTACT_MODE(ONE_CONTACT_MODE), .BREAKER_READY(BREAKER_READY),
		.BREAKER_REMOVED(BREAKER_REMOVED),
		.CLOSE_LOCKOUT_INPUT(CLOSE_LOCKOUT_INPUT),
		.OPEN_LOCKOUT_INPUT(OPEN_LOCKOUT_INPUT), .CLOSE_REQ(CLOSE_REQ),
		.OPEN_REQ(OPEN_REQ), .SYNC_CLOSE_MODE(SYNC_CLOSE_MODE),
		.IN_SYNC(IN_SYNC), .PROT_CLOSE_REQ(PROT_CLOSE_REQ),
		.INCL_PROT_CLOSE(INCL_PROT_CLOSE), .PROT_TRIP(PROT_TRIP),
		.TRIP_ACK(TRIP_ACK), .AUTO_ACK(AUTO_ACK), .POSITION(POSITION),
		.ONE_CONTACT_MODE_FLAG(ONE_CONTACT_MODE_FLAG),
		.POS_CLOSED(POS_CLOSED), .POS_OPEN(POS_OPEN),
		.POS_NOT_CLOSED(POS_NOT_CLOSED), .POS_INDETERMINATE(POS_INDETERMINATE),
		.POS_DISTURBED(POS_DISTURBED), .CLOSE_LOCKOUT(CLOSE_LOCKOUT),
		.OPEN_LOCKOUT(OPEN_LOCKOUT), .READY(READY), .REMOVED(REMOVED),
		.CLOSE_CMD(CLOSE_CMD), .OPEN_CMD(OPEN_CMD),
		.PROT_CLOSE_INCLUDED(PROT_CLOSE_INCLUDED),
		.PROTECTION_TRIP_REQUEST(PROTECTION_TRIP_REQUEST),
		.TRIP_ACKNOWLEDGE(TRIP_ACKNOWLEDGE), .DWELL_ACTIVE(DWELL_ACTIVE),
		.CMD_STATUS(CMD_STATUS));

	breaker_drive_model model (.clk(CLK), .rst(RST), .close_cmd(CLOSE_CMD),
		.open_cmd(OPEN_CMD), .jam(jam), .aux_closed(AUX_CLOSED),
		.aux_open(AUX_OPEN));

	// Ten bits so a status bit placed above the nine flags is not lost
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : cyc

	// Pulse one request, then look just after the edge that follows the answer edge
	task automatic req(input logic c, input logic o);
		@(posedge CLK);
		CLOSE_REQ <= c;
		OPEN_REQ  <= o;
		@(posedge CLK);
		CLOSE_REQ <= 1'b0;
		OPEN_REQ  <= 1'b0;
		cyc(1);
	endtask : req

	// Bounded wait for the end of an execution
	task automatic wait_idle();
		for (int i = 0; i < 100 && DWELL_ACTIVE !== 1'b0; i++) cyc(1);
	endtask : wait_idle

	task automatic t_cycle();
		chk({POSITION, POS_OPEN, POS_NOT_CLOSED, POS_CLOSED}, 9'h00e);
		req(1'b1, 1'b0);
		chk({CLOSE_CMD, DWELL_ACTIVE}, 9'h003);
		wait_idle();
		chk(CMD_STATUS, 9'h100);
		chk({POSITION, POS_CLOSED, POS_NOT_CLOSED}, 9'h00a);
		req(1'b1, 1'b0);
		chk(CMD_STATUS, 9'h020);
		req(1'b0, 1'b1);
		chk({OPEN_CMD, DWELL_ACTIVE}, 9'h003);
		req(1'b1, 1'b0);
		wait_idle();
		chk(CMD_STATUS, 9'h110);
		chk(POSITION, POS_OPEN_CODE);
	endtask : t_cycle

	task automatic t_refusals();
		for (int i = 0; i < NUM_LOCKOUTS; i++) begin
			@(posedge CLK);
			CLOSE_LOCKOUT_INPUT <= 3'h1 << i;
			OPEN_LOCKOUT_INPUT  <= 3'h1 << i;
			req(1'b1, 1'b0);
			chk({CLOSE_LOCKOUT, OPEN_LOCKOUT}, 9'h003);
			chk(CMD_STATUS, 9'h004);
		end
		CLOSE_LOCKOUT_INPUT <= '0;
		OPEN_LOCKOUT_INPUT  <= '0;
		BREAKER_READY       <= 1'b0;
		req(1'b1, 1'b0);
		chk({READY, CMD_STATUS}, 10'h008);
		BREAKER_READY   <= 1'b1;
		BREAKER_REMOVED <= 1'b1;
		req(1'b1, 1'b0);
		chk({REMOVED, CMD_STATUS}, 10'h201);
		BREAKER_REMOVED <= 1'b0;
		PROT_TRIP       <= 1'b1;
		req(1'b1, 1'b0);
		chk({PROTECTION_TRIP_REQUEST, CMD_STATUS}, 10'h240);
		PROT_TRIP <= 1'b0;
		TRIP_ACK  <= 1'b1;
		cyc(1);
		chk({PROTECTION_TRIP_REQUEST, TRIP_ACKNOWLEDGE}, 9'h001);
		TRIP_ACK <= 1'b0;
		cyc(1);
		chk(TRIP_ACKNOWLEDGE, 9'h000);
		// Automatic acknowledge clears the latch once the trip goes
		AUTO_ACK  <= 1'b1;
		PROT_TRIP <= 1'b1;
		cyc(2);
		chk(PROTECTION_TRIP_REQUEST, 9'h001);
		PROT_TRIP <= 1'b0;
		cyc(1);
		chk({PROTECTION_TRIP_REQUEST, TRIP_ACKNOWLEDGE}, 9'h001);
		AUTO_ACK <= 1'b0;
	endtask : t_refusals

	task automatic t_contacts();
		SYNC_CLOSE_MODE <= 1'b1;
		req(1'b1, 1'b0);
		chk({CLOSE_CMD, CMD_STATUS}, 9'h000);
		cyc(24);
		chk({CLOSE_CMD, CMD_STATUS}, 9'h002);
		// In-sync present: drive rises on the same edge that sees it in ST_SYNC
		IN_SYNC <= 1'b1;
		req(1'b1, 1'b0);
		chk({CLOSE_CMD, CMD_STATUS}, 10'h200);
		wait_idle();
		chk(CMD_STATUS, 9'h100);
		IN_SYNC         <= 1'b0;
		SYNC_CLOSE_MODE <= 1'b0;
		jam             <= 1'b1;
		cyc(5);
		chk({POSITION, POS_INDETERMINATE}, 9'h001);
		cyc(6);
		chk({POSITION, POS_DISTURBED}, 9'h007);
		req(1'b1, 1'b0);
		wait_idle();
		chk(CMD_STATUS, 9'h080);
		ONE_CONTACT_MODE <= 1'b1;
		cyc(3);
		chk({POSITION, ONE_CONTACT_MODE_FLAG}, 9'h003);
		jam              <= 1'b0;
		ONE_CONTACT_MODE <= 1'b0;
		INCL_PROT_CLOSE  <= 1'b1;
		PROT_CLOSE_REQ   <= 1'b1;
		cyc(3);
		chk({CLOSE_CMD, PROT_CLOSE_INCLUDED}, 9'h003);
	endtask : t_contacts

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	// Watchdog well above the under two hundred cycles the scenarios need
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	initial begin
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		cyc(3);
		t_cycle();
		t_refusals();
		t_contacts();
		summarize();
	end
endmodule : breaker_command_supervision_bench
